//--- rtl/ccx_pkg.sv
// constants, opcodes and carriers for the call/clear/complement execution block
// assumes a 40 MHz core clock and the one-word-per-cycle fetch of the core
package ccx_pkg;

  localparam int unsigned CLK_HZ         = 40000000;
  localparam int unsigned PC_W           = 21;
  localparam int unsigned ADDR_W         = 12;

  // opcode prefixes, compared on the upper instruction bits; the re-arm word is compared whole
  localparam logic [6:0]  OP_CALL_HI     = 7'h76;   // 1110 110s
  localparam logic [3:0]  OP_CALL_WORD2  = 4'hF;    // 1111 kkkk
  localparam logic [6:0]  OP_ZERO_HI     = 7'h35;   // 0110 101a
  localparam logic [5:0]  OP_INVERT_HI   = 6'h07;   // 0001 11da
  localparam logic [15:0] OP_REARM      = 16'h0004;

  // field positions inside an instruction word
  localparam int unsigned BIT_SHADOW     = 8;
  localparam int unsigned BIT_ACCESS     = 8;
  localparam int unsigned BIT_DEST       = 9;

  // addressing
  localparam logic [7:0]  INDEX_MAX      = 8'h5F;   // 95
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [PC_W-1:0] RET_STEP   = 21'h000004;

  // reset values
  localparam logic        TIMEOUT_RST    = 1'b1;
  localparam logic        POWERDOWN_RST  = 1'b1;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  typedef enum logic [1:0] {
    CCX_FIRST = 2'b01,
    CCX_WORD2 = 2'b10
  } ccx_state_e;

  // working registers copied on a shadowed call
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] flags;
    logic [3:0] bank;
  } ccx_ctx_s;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } ccx_wr_s;

endpackage : ccx_pkg

//--- rtl/ccx_exec.sv
// execution of call, zero-register, watchdog re-arm and invert-register
// assumes a combinational register-file read port and one instruction per cycle
//
// The implementer's own choices: the placing of the registers and strobed register access.

// Overview of operation
// - call target covers the whole 2-Mbyte program space
// - call pushes its own address plus four before redirecting
// - shadow bit one copies accumulator, flags and bank select into shadows
// - shadow bit zero leaves all three shadow copies untouched
// - 20-bit literal loads counter bits 20..1, bit 0 stays zero
// - call is two words, two cycles; second cycle is a no-op
// - zero-register writes zero and sets the zero flag
// - access bit zero resolves the operand in the access bank
// - access bit one forms address from bank select and operand
// - extended set with access bit zero indexes when operand is at most 95
// - watchdog re-arm zeroes counter and postscaler, sets timeout and powerdown
// - invert-register complements the operand and updates negative and zero
// - destination zero goes to accumulator, one back to the register
module ccx_exec import ccx_pkg::*; (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  // instruction stream
  input  wire logic                   instr_valid_in,
  input  wire logic [15:0]            instr_in,
  input  wire logic [PC_W-1:0]        instr_addr_in,
  input  wire logic                   ext_set_in,
  input  wire logic [ADDR_W-1:0]      index_base_in,
  // core context
  input  wire ccx_pkg::ccx_ctx_s      ctx_in,
  input  wire logic [7:0]             reg_rdata_in,
  // watchdog events that drop the flags
  input  wire logic                   wdt_expired_in,
  input  wire logic                   sleep_entry_in,
  // register file and accumulator
  output logic [ADDR_W-1:0]           reg_raddr_out,
  output ccx_pkg::ccx_wr_s            reg_wr_out,
  output logic                        acc_wr_out,
  output logic [7:0]                  acc_data_out,
  // flags
  output logic                        flag_upd_out,
  output logic                        zero_flag_out,
  output logic                        neg_flag_out,
  output logic                        timeout_flag_out,
  output logic                        powerdown_flag_out,
  // return stack, counter, shadows
  output logic                        stack_push_out,
  output logic [PC_W-1:0]             return_stack_top_out,
  output logic                        pc_load_out,
  output logic [PC_W-1:0]             program_counter_out,
  output ccx_pkg::ccx_ctx_s           shadow_out,
  output logic                        call_nop_out,
  // watchdog
  output logic                        watchdog_clear_out
);
  import ccx_pkg::*;

  typedef struct packed {
    ccx_state_e      st;
    logic [PC_W-1:0] ret;
    logic            push;
    logic            pc_load;
    logic [PC_W-1:0] pc;
    logic            nop;
    ccx_wr_s         wr;
    logic            acc_wr;
    logic [7:0]      acc;
    logic            upd;
    logic            zf;
    logic            nf;
    logic            to;
    logic            pd;
    logic            wdt_clr;
    ccx_ctx_s        sh;
    logic [7:0]      klo;
  } ccx_regs_s;

  localparam ccx_regs_s REGS_RST = '{
    st: CCX_FIRST, ret: '0, push: 1'b0, pc_load: 1'b0, pc: '0, nop: 1'b0,
    wr: '0, acc_wr: 1'b0, acc: ZERO_BYTE, upd: 1'b0, zf: 1'b0, nf: 1'b0,
    to: TIMEOUT_RST, pd: POWERDOWN_RST, wdt_clr: 1'b0, sh: '0, klo: ZERO_BYTE
  };

  ccx_regs_s r;
  ccx_regs_s next_r;

  logic       is_call;
  logic       is_word2;
  logic       is_zero;
  logic       is_invert;
  logic       is_rearm;
  logic [7:0] f_op;
  logic [7:0] inv_val;

  assign f_op      = instr_in[7:0];
  assign inv_val   = ~reg_rdata_in;
  // the second call word is only legal while a call is pending
  assign is_word2  = instr_valid_in && (r.st == CCX_WORD2)
                     && (instr_in[15:12] == OP_CALL_WORD2);
  assign is_call   = instr_valid_in && (r.st == CCX_FIRST)
                     && (instr_in[15:9] == OP_CALL_HI);
  assign is_zero   = instr_valid_in && (r.st == CCX_FIRST)
                     && (instr_in[15:9] == OP_ZERO_HI);
  assign is_invert = instr_valid_in && (r.st == CCX_FIRST)
                     && (instr_in[15:10] == OP_INVERT_HI);
  assign is_rearm  = instr_valid_in && (r.st == CCX_FIRST)
                     && (instr_in == OP_REARM);

  // operand address, looked up in the same cycle as decode
  always_comb begin
    if (instr_in[BIT_ACCESS]) begin
      reg_raddr_out = {ctx_in.bank, f_op};
    end else if (ext_set_in && (f_op <= INDEX_MAX)) begin
      reg_raddr_out = index_base_in + {4'h0, f_op};
    end else if (f_op < ACCESS_SPLIT) begin
      reg_raddr_out = {4'h0, f_op};
    end else begin
      reg_raddr_out = {ACCESS_HI_BANK, f_op};
    end
  end

  always_comb begin
    next_r         = r;
    // pulses last one cycle; single-word ops finish in their own cycle
    next_r.push    = 1'b0;
    next_r.pc_load = 1'b0;
    next_r.nop     = 1'b0;
    next_r.wr.en   = 1'b0;
    next_r.acc_wr  = 1'b0;
    next_r.upd     = 1'b0;
    next_r.wdt_clr = 1'b0;
    // flag drops first so a re-arm in the same cycle wins
    if (wdt_expired_in) begin
      next_r.to = 1'b0;
    end
    if (sleep_entry_in) begin
      next_r.pd = 1'b0;
    end
    case (r.st)
      CCX_FIRST: begin
        if (is_call) begin
          next_r.push = 1'b1;
          next_r.ret  = instr_addr_in + RET_STEP;
          next_r.klo  = f_op;
          next_r.st   = CCX_WORD2;
          if (instr_in[BIT_SHADOW]) begin
            next_r.sh = ctx_in;
          end
          // shadow bit clear: shadows keep their value
        end else if (is_zero) begin
          next_r.wr   = '{en: 1'b1, addr: reg_raddr_out, data: ZERO_BYTE};
          next_r.upd  = 1'b1;
          next_r.zf   = 1'b1;
          next_r.nf   = 1'b0;
        end else if (is_invert) begin
          next_r.upd  = 1'b1;
          next_r.zf   = (inv_val == ZERO_BYTE);
          next_r.nf   = inv_val[7];
          if (instr_in[BIT_DEST]) begin
            next_r.wr = '{en: 1'b1, addr: reg_raddr_out, data: inv_val};
          end else begin
            next_r.acc_wr = 1'b1;
            next_r.acc    = inv_val;
          end
        end else if (is_rearm) begin
          next_r.wdt_clr = 1'b1;
          next_r.to      = 1'b1;
          next_r.pd      = 1'b1;
        end
      end
      CCX_WORD2: begin
        if (is_word2) begin
          // full 20-bit word target spans 2 Mbyte; bit 0 is never loaded
          next_r.pc      = {instr_in[11:0], r.klo, 1'b0};
          next_r.pc_load = 1'b1;
          next_r.nop     = 1'b1;
          next_r.st      = CCX_FIRST;
        end
      end
      default: begin
        next_r.st = CCX_FIRST;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= REGS_RST;
    end else begin
      r <= next_r;
    end
  end

  assign reg_wr_out           = r.wr;
  assign acc_wr_out           = r.acc_wr;
  assign acc_data_out         = r.acc;
  assign flag_upd_out         = r.upd;
  assign zero_flag_out        = r.zf;
  assign neg_flag_out         = r.nf;
  assign timeout_flag_out     = r.to;
  assign powerdown_flag_out   = r.pd;
  assign stack_push_out       = r.push;
  assign return_stack_top_out = r.ret;
  assign pc_load_out          = r.pc_load;
  assign program_counter_out  = r.pc;
  assign shadow_out           = r.sh;
  assign call_nop_out         = r.nop;
  assign watchdog_clear_out   = r.wdt_clr;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_call_word1;
    is_call;
  endsequence

  sequence s_call_word2;
    is_word2;
  endsequence

  a_call_push_ret: assert property (
    s_call_word1 |=> stack_push_out && (return_stack_top_out == $past(instr_addr_in) + RET_STEP)
  ) else $error("call did not push its address plus four");

  a_push_before_load: assert property (
    s_call_word1 ##1 s_call_word2 |=> pc_load_out && call_nop_out && $past(stack_push_out)
  ) else $error("call redirect not preceded by push");

  a_call_target: assert property (
    s_call_word2 |=> program_counter_out == {$past(instr_in[11:0]), $past(r.klo), 1'b0}
  ) else $error("call target bits misloaded");

  a_target_bit0: assert property (
    pc_load_out |-> !program_counter_out[0]
  ) else $error("counter bit zero loaded");

  a_shadow_copy: assert property (
    (s_call_word1 and instr_in[BIT_SHADOW]) |=> shadow_out == $past(ctx_in)
  ) else $error("shadow copy missing");

  a_shadow_hold: assert property (
    !(is_call && instr_in[BIT_SHADOW]) |=> $stable(shadow_out)
  ) else $error("shadow changed without request");

  a_zero_reg: assert property (
    is_zero |=> reg_wr_out.en && reg_wr_out.data == ZERO_BYTE && zero_flag_out
  ) else $error("zero-register result wrong");

  a_bank_addr: assert property (
    is_zero && instr_in[BIT_ACCESS] |=> reg_wr_out.addr == {$past(ctx_in.bank), $past(f_op)}
  ) else $error("banked address wrong");

  a_index_addr: assert property (
    is_invert && !instr_in[BIT_ACCESS] && ext_set_in && f_op <= INDEX_MAX
      |-> reg_raddr_out == index_base_in + {4'h0, f_op}
  ) else $error("indexed address wrong");

  a_access_addr: assert property (
    instr_valid_in && !instr_in[BIT_ACCESS] && !ext_set_in |-> reg_raddr_out[11:8] == 4'h0
      || reg_raddr_out[11:8] == ACCESS_HI_BANK
  ) else $error("access bank address wrong");

  // back-to-back re-arms are legal, so the clear pulse may legally repeat
  a_rearm_flags: assert property (
    is_rearm |=> watchdog_clear_out && timeout_flag_out && powerdown_flag_out
      ##1 (!watchdog_clear_out || $past(is_rearm))
  ) else $error("re-arm effects wrong");

  a_invert_dest: assert property (
    is_invert |=> (acc_wr_out != reg_wr_out.en)
      && (acc_wr_out ? acc_data_out : reg_wr_out.data) == ~$past(reg_rdata_in)
  ) else $error("invert destination wrong");

  a_invert_flags: assert property (
    is_invert |=> flag_upd_out
      && (neg_flag_out == (acc_wr_out ? acc_data_out[7] : reg_wr_out.data[7]))
  ) else $error("invert flags wrong");

  a_invert_zero: assert property (
    is_invert
      |=> zero_flag_out == ($past(reg_rdata_in) == 8'hFF)
  ) else $error("invert zero flag wrong");

  a_single_cycle: assert property (
    (is_zero || is_invert || is_rearm) |=> r.st == CCX_FIRST
      ##1 (!flag_upd_out || $past(is_zero || is_invert))
  ) else $error("single-word op did not finish in one cycle");

  a_rearm_single: assert property (
    is_rearm
      |=> !flag_upd_out && !reg_wr_out.en && !acc_wr_out
  ) else $error("re-arm touched register or flags");

  a_call_state: assert property (
    is_call
      |=> r.st == CCX_WORD2 && !pc_load_out
  ) else $error("call did not wait for its second word");

  // a stray word during a pending call must not leak any side effect
  a_pending_ignore: assert property (
    r.st == CCX_WORD2 && !is_word2
      |=> !pc_load_out && !reg_wr_out.en && !flag_upd_out && !watchdog_clear_out
  ) else $error("stray word acted while call pending");

  a_word2_load: assert property (
    is_word2
      |=> pc_load_out && call_nop_out && !stack_push_out
  ) else $error("second call word did not load the counter");

  a_push_pulse: assert property (
    stack_push_out
      |=> !stack_push_out
  ) else $error("return push longer than one cycle");

  a_ret_hold: assert property (
    !is_call
      |=> $stable(return_stack_top_out)
  ) else $error("return address changed without a call");

  a_pc_hold: assert property (
    !is_word2
      |=> $stable(program_counter_out) && !pc_load_out
  ) else $error("counter changed without a call");

  a_zero_neg: assert property (
    is_zero
      |=> flag_upd_out && !neg_flag_out && !acc_wr_out
  ) else $error("zero-register flags wrong");

  a_access_low: assert property (
    is_zero && !instr_in[BIT_ACCESS] && !ext_set_in && f_op < ACCESS_SPLIT
      |=> reg_wr_out.addr == {4'h0, $past(f_op)}
  ) else $error("low access bank address wrong");

  a_access_high: assert property (
    is_zero && !instr_in[BIT_ACCESS] && f_op >= ACCESS_SPLIT
      |=> reg_wr_out.addr == {ACCESS_HI_BANK, $past(f_op)}
  ) else $error("high access bank address wrong");

  a_bank_invert: assert property (
    is_invert && instr_in[BIT_ACCESS] && instr_in[BIT_DEST]
      |=> reg_wr_out.addr == {$past(ctx_in.bank), $past(f_op)}
  ) else $error("banked invert address wrong");

  a_index_zero: assert property (
    is_zero && !instr_in[BIT_ACCESS] && ext_set_in && f_op <= INDEX_MAX
      |=> reg_wr_out.addr == $past(index_base_in) + {4'h0, $past(f_op)}
  ) else $error("indexed zero-register address wrong");

  a_acc_hold: assert property (
    is_invert && instr_in[BIT_DEST]
      |=> !acc_wr_out && $stable(acc_data_out)
  ) else $error("accumulator touched by register-destined invert");

  // only a re-arm may raise the timeout flag outside reset
  a_timeout_hold: assert property (
    !is_rearm && !wdt_expired_in
      |=> timeout_flag_out == $past(timeout_flag_out)
  ) else $error("timeout flag moved without cause");

endmodule : ccx_exec

//--- tb/tb_top.sv
// self-checking bench for the call/zero/invert/re-arm execution block
// assumes the block answers one cycle after the taking edge, no separate partner model
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ccx_pkg::*;

  logic              clk_in         = 1'h0;
  logic              sys_rst_in     = 1'h1;
  logic              instr_valid_in = 1'h0;
  logic [15:0]       instr_in       = 16'h0000;
  logic [PC_W-1:0]   instr_addr_in  = 21'h000000;
  logic              ext_set_in     = 1'h0;
  logic [ADDR_W-1:0] index_base_in  = 12'h000;
  ccx_ctx_s          ctx_in         = 20'h00000;
  logic [7:0]        reg_rdata_in   = 8'h00;
  logic              wdt_expired_in = 1'h0;
  logic              sleep_entry_in = 1'h0;
  logic [ADDR_W-1:0] reg_raddr_out;
  ccx_wr_s           reg_wr_out;
  logic              acc_wr_out;
  logic [7:0]        acc_data_out;
  logic              flag_upd_out;
  logic              zero_flag_out;
  logic              neg_flag_out;
  logic              timeout_flag_out;
  logic              powerdown_flag_out;
  logic              stack_push_out;
  logic [PC_W-1:0]   return_stack_top_out;
  logic              pc_load_out;
  logic [PC_W-1:0]   program_counter_out;
  ccx_ctx_s          shadow_out;
  logic              call_nop_out;
  logic              watchdog_clear_out;
  int                n_mismatch     = 0;
  int                checked        = 0;

  ccx_exec u_ccx_exec (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .instr_addr_in(instr_addr_in), .ext_set_in(ext_set_in),
    .index_base_in(index_base_in), .ctx_in(ctx_in), .reg_rdata_in(reg_rdata_in),
    .wdt_expired_in(wdt_expired_in), .sleep_entry_in(sleep_entry_in),
    .reg_raddr_out(reg_raddr_out), .reg_wr_out(reg_wr_out), .acc_wr_out(acc_wr_out),
    .acc_data_out(acc_data_out), .flag_upd_out(flag_upd_out), .zero_flag_out(zero_flag_out),
    .neg_flag_out(neg_flag_out), .timeout_flag_out(timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out), .stack_push_out(stack_push_out),
    .return_stack_top_out(return_stack_top_out), .pc_load_out(pc_load_out),
    .program_counter_out(program_counter_out), .shadow_out(shadow_out),
    .call_nop_out(call_nop_out), .watchdog_clear_out(watchdog_clear_out));

  always #12.5 clk_in = ~clk_in;

  function automatic logic [11:0] exp_addr(input logic a, input logic [7:0] f);
    if (a) return {ctx_in.bank, f};
    if (ext_set_in && f <= 8'h5F) return index_base_in + {4'h0, f};
    if (f < 8'h60) return {4'h0, f};
    return {4'hF, f};
  endfunction : exp_addr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one cycle of stimulus, then wait to the falling edge, where the previous word's registered results are settled
  task automatic step(input logic v, input logic [15:0] w, input logic [1:0] ev);
    @(posedge clk_in);
    instr_valid_in <= v;
    instr_in       <= w;
    sleep_entry_in <= ev[1];
    wdt_expired_in <= ev[0];
    @(negedge clk_in);
  endtask : step

  task automatic results();
    $display("checked=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  initial begin
    repeat (5000) @(posedge clk_in);
    n_mismatch++;
    results();
  end

  initial begin
    logic [7:0]  f;
    logic [7:0]  r;
    logic [11:0] ea;
    logic [19:0] k;
    logic        a;
    logic        d;
    logic        s;
    ccx_ctx_s    sh;
    void'($urandom(12940));
    sh = 20'h00000;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(negedge clk_in);
    chk(timeout_flag_out, 1'h1);
    chk(shadow_out, sh);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_in);
      ctx_in        <= ccx_ctx_s'($urandom);
      ext_set_in    <= (i < 8) ? i[2] : 1'($urandom);
      index_base_in <= 12'($urandom);
      instr_addr_in <= 21'($urandom);
      reg_rdata_in  <= (i == 1) ? 8'hFF : 8'($urandom);
      // boundary operands first, around the indexed and access-bank splits
      f = (i < 8) ? ((i[0]) ? 8'h5F : 8'h60) : 8'($urandom);
      a = (i < 8) ? i[1] : 1'($urandom);
      d = 1'($urandom);
      s = i[0] ^ i[3];
      k = (i == 2) ? 20'hFFFFF : 20'($urandom);
      step(1'h1, {7'h35, a, f}, 2'h0);
      ea = exp_addr(a, f);
      chk(reg_raddr_out, ea);
      step(1'h1, {6'h07, d, a, f}, 2'h0);
      chk(reg_wr_out, {1'h1, ea, 8'h00});
      chk({flag_upd_out, zero_flag_out, neg_flag_out}, 3'h6);
      r = ~reg_rdata_in;
      step(1'h1, {7'h76, s, k[7:0]}, 2'h0);
      chk(reg_wr_out, d ? {1'h1, ea, r} : {1'h0, ea, 8'h00});
      chk({acc_wr_out, acc_wr_out ? acc_data_out : r}, {~d, r});
      chk({flag_upd_out, zero_flag_out, neg_flag_out}, {1'h1, r == 8'h00, r[7]});
      if (s) sh = ctx_in;
      // a stray word while the call waits for its second word is ignored
      step(1'h1, (i < 10) ? {7'h35, a, f} : {4'hF, k[19:8]}, 2'h0);
      chk({stack_push_out, return_stack_top_out}, {1'h1, instr_addr_in + 21'h000004});
      chk(shadow_out, sh);
      chk(pc_load_out, 1'h0);
      if (i < 10) begin
        step(1'h1, {4'hF, k[19:8]}, 2'h0);
        chk({reg_wr_out.en, pc_load_out, stack_push_out}, 3'h0);
      end
      step(1'h0, 16'h0000, 2'h1);
      chk({pc_load_out, call_nop_out, program_counter_out}, {2'h3, k, 1'h0});
      step(1'h0, 16'h0000, 2'h2);
      chk({call_nop_out, timeout_flag_out}, 2'h0);
      step(1'h1, OP_REARM, i[0] ? 2'h3 : 2'h0);
      chk(powerdown_flag_out, 1'h0);
      step(1'h0, 16'h0000, 2'h0);
      chk({watchdog_clear_out, timeout_flag_out, powerdown_flag_out}, 3'h7);
      step(1'h0, 16'h0000, 2'h0);
      chk(watchdog_clear_out, 1'h0);
    end
    // second reset mid-run with both flags dropped; they must come back high
    step(1'h0, 16'h0000, 2'h3);
    @(posedge clk_in);
    sys_rst_in     <= 1'h1;
    wdt_expired_in <= 1'h0;
    sleep_entry_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'h0;
    @(negedge clk_in);
    chk({timeout_flag_out, powerdown_flag_out, stack_push_out}, 3'h6);
    chk(shadow_out, 20'h00000);
    step(1'h1, OP_REARM, 2'h0);
    step(1'h0, 16'h0000, 2'h0);
    chk(watchdog_clear_out, 1'h1);
    results();
  end
endmodule : tb_top
